/* File: src/adc_acq_ctrl.sv */
// Acquisition and conversion-clock sequencer for a 10-bit successive-approximation converter.
// Assumes software drives the control strobes on core_clk and the RC clock is asynchronous.
//
// Operation
// - Three-bit acquisition field selects automatic acquisition of 2 to 20 bit periods.
// - Nonzero field: start keeps sampling for the period, then converts unaided.
// - Zero field: start stops sampling and begins conversion at once.
// - Acquisition field resets to zero, giving manual acquisition mode.
// - On completion clear start/done, set complete flag, resume sampling.
// - Besides the two select fields, only start/done and complete flag are visible to software.
// - Each conversion takes exactly 11 bit periods.
// - Clock select chooses oscillator divided 2 to 64, or the RC oscillator.
// - Complete flag stays set until software clears it.
`timescale 1ns/1ps
module adc_acq_ctrl
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ctl_wr,
    input wire adc_seq_pkg::ctl_word_s ctl_wdata,
    input wire logic start_set,
    input wire logic flag_clear,
    input wire logic rc_osc,
    output logic [2:0] acq_time_select,
    output logic [2:0] conv_clock_select,
    output logic start_done,
    output logic conv_complete_flag,
    output logic sampling,
    output logic conv_start,
    output logic bit_strobe
);

    adc_seq_pkg::ctrl_s st_reg;
    adc_seq_pkg::ctrl_s st_next;
    logic tick;
    logic rc_rise;
    logic restart;
    logic take_start;
    logic conv_end;

    // ------------------------------------------------------------
    // Conversion clock
    // ------------------------------------------------------------
    // The RC clock edge is taken from the second and third sync stages only.
    assign rc_rise = st_reg.rc_sync[1] && !st_reg.rc_sync[2];
    assign take_start = (st_reg.state == adc_seq_pkg::ST_SAMPLE) && start_set;
    assign restart = take_start;

    tad_divider u_div
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_sel(st_reg.ctl.clk_sel),
        .restart(restart),
        .rc_rise(rc_rise),
        .tick(tick)
    );

    assign conv_end = (st_reg.state == adc_seq_pkg::ST_CONV) && tick && (st_reg.cnt == 5'h01);

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Acquisition versus conversion is not reported to software, only to the core.
    assign start_done = st_reg.start_done;
    assign conv_complete_flag = st_reg.flag;
    assign acq_time_select = st_reg.ctl.acq_sel;
    assign conv_clock_select = st_reg.ctl.clk_sel;
    assign sampling = (st_reg.state != adc_seq_pkg::ST_CONV);
    assign conv_start = st_reg.conv_start;
    assign bit_strobe = (st_reg.state == adc_seq_pkg::ST_CONV) && tick;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Acquisition length is latched at start, but a clock-select rewrite mid-sequence changes the bit period at once.
    always_comb
    begin
        st_next = st_reg;
        st_next.conv_start = 1'b0;
        st_next.rc_sync = {st_reg.rc_sync[1:0], rc_osc};
        if (ctl_wr)
        begin
            st_next.ctl = ctl_wdata;
        end
        unique case (st_reg.state)
            adc_seq_pkg::ST_SAMPLE:
            begin
                if (start_set)
                begin
                    st_next.start_done = 1'b1;
                    if (st_reg.ctl.acq_sel == adc_seq_pkg::ACQ_MANUAL)
                    begin
                        st_next.state = adc_seq_pkg::ST_CONV;
                        st_next.cnt = adc_seq_pkg::CONV_PERIODS;
                        st_next.conv_start = 1'b1;
                    end
                    else
                    begin
                        st_next.state = adc_seq_pkg::ST_ACQ;
                        st_next.cnt = adc_seq_pkg::acq_len(st_reg.ctl.acq_sel);
                    end
                end
            end
            adc_seq_pkg::ST_ACQ:
            begin
                // A further start here is simply not looked at.
                if (tick)
                begin
                    if (st_reg.cnt == 5'h01)
                    begin
                        st_next.state = adc_seq_pkg::ST_CONV;
                        st_next.cnt = adc_seq_pkg::CONV_PERIODS;
                        st_next.conv_start = 1'b1;
                    end
                    else
                    begin
                        st_next.cnt = st_reg.cnt - 5'h01;
                    end
                end
            end
            adc_seq_pkg::ST_CONV:
            begin
                if (tick)
                begin
                    if (st_reg.cnt == 5'h01)
                    begin
                        st_next.state = adc_seq_pkg::ST_SAMPLE;
                        st_next.start_done = 1'b0;
                        st_next.cnt = 5'h00;
                    end
                    else
                    begin
                        st_next.cnt = st_reg.cnt - 5'h01;
                    end
                end
            end
            default:
            begin
                st_next.state = adc_seq_pkg::ST_SAMPLE;
            end
        endcase
        // Completion beats a clear in the same cycle so no event is lost.
        if (conv_end)
        begin
            st_next.flag = 1'b1;
        end
        else if (flag_clear)
        begin
            st_next.flag = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg.state <= adc_seq_pkg::ST_SAMPLE;
            st_reg.cnt <= 5'h00;
            st_reg.start_done <= 1'b0;
            st_reg.flag <= 1'b0;
            st_reg.ctl.acq_sel <= adc_seq_pkg::ACQ_SEL_RESET;
            st_reg.ctl.clk_sel <= adc_seq_pkg::CLK_SEL_RESET;
            st_reg.conv_start <= 1'b0;
            st_reg.rc_sync <= 3'h0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Period counters seen only by the checks below.
    logic [4:0] conv_ticks;
    logic [4:0] acq_ticks;
    logic [4:0] acq_expect;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_ticks <= 5'h00;
            acq_ticks <= 5'h00;
            acq_expect <= 5'h00;
        end
        else
        begin
            if (st_reg.state != adc_seq_pkg::ST_CONV)
            begin
                conv_ticks <= 5'h00;
            end
            else if (tick)
            begin
                conv_ticks <= conv_ticks + 5'h01;
            end
            if (take_start)
            begin
                acq_expect <= adc_seq_pkg::acq_len(st_reg.ctl.acq_sel);
                acq_ticks <= 5'h00;
            end
            else if (st_reg.state == adc_seq_pkg::ST_ACQ && tick)
            begin
                acq_ticks <= acq_ticks + 5'h01;
            end
        end
    end

    field_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(acq_time_select) |-> $past(ctl_wr))
        else $error("Acquisition field changed without a control write.");

    manual_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (take_start && acq_time_select == 3'h0) |=> (!sampling && conv_start && start_done))
        else $error("Manual start did not begin conversion at once.");

    auto_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (take_start && acq_time_select != 3'h0) |=> (sampling && start_done && !conv_start))
        else $error("Programmed start did not keep sampling.");

    acq_length_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_reg.state == adc_seq_pkg::ST_ACQ && $past(st_reg.state) == adc_seq_pkg::ST_ACQ
            && st_next.state == adc_seq_pkg::ST_CONV) |-> (acq_ticks + 5'h01 == acq_expect))
        else $error("Acquisition period length wrong.");

    conv_length_a: assert property (@(posedge core_clk) disable iff (!rstn)
        conv_end |-> (conv_ticks == 5'h0A))
        else $error("Conversion did not take eleven bit periods.");

    done_effect_a: assert property (@(posedge core_clk) disable iff (!rstn)
        conv_end |=> (!start_done && conv_complete_flag && sampling))
        else $error("Completion effects missing.");

    flag_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (conv_complete_flag && !flag_clear) |=> conv_complete_flag)
        else $error("Complete flag dropped without a clear.");

    busy_ignore_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_reg.state == adc_seq_pkg::ST_ACQ && start_set && !tick)
            |=> (st_reg.cnt == $past(st_reg.cnt) && st_reg.state == adc_seq_pkg::ST_ACQ))
        else $error("Start during a sequence disturbed it.");

endmodule

/* File: src/adc_seq_pkg.sv */
// Shared constants, types and lookup functions for the converter sequencer.
// Assumes one core clock; all counts are in conversion-clock periods or core cycles.
package adc_seq_pkg;

    // ------------------------------------------------------------
    // Reset values and fixed counts
    // ------------------------------------------------------------
    localparam logic [2:0] ACQ_SEL_RESET = 3'h0;
    localparam logic [2:0] CLK_SEL_RESET = 3'h0;
    localparam logic [4:0] CONV_PERIODS = 5'h0B;
    localparam logic [2:0] ACQ_MANUAL = 3'h0;
    localparam int ACQ_FIELD_LSB = 3;
    localparam int ACQ_FIELD_MSB = 5;
    localparam int FLAG_BIT_POS = 6;

    // ------------------------------------------------------------
    // Acquisition lengths per nonzero code, rising monotonically
    // ------------------------------------------------------------
    localparam logic [4:0] ACQ_LEN_1 = 5'h02;
    localparam logic [4:0] ACQ_LEN_2 = 5'h04;
    localparam logic [4:0] ACQ_LEN_3 = 5'h06;
    localparam logic [4:0] ACQ_LEN_4 = 5'h08;
    localparam logic [4:0] ACQ_LEN_5 = 5'h0C;
    localparam logic [4:0] ACQ_LEN_6 = 5'h10;
    localparam logic [4:0] ACQ_LEN_7 = 5'h14;

    // ------------------------------------------------------------
    // Conversion clock select codes and core-clock divide ratios
    // ------------------------------------------------------------
    localparam logic [2:0] CSEL_DIV2 = 3'h0;
    localparam logic [2:0] CSEL_DIV4 = 3'h4;
    localparam logic [2:0] CSEL_DIV8 = 3'h1;
    localparam logic [2:0] CSEL_DIV16 = 3'h5;
    localparam logic [2:0] CSEL_DIV32 = 3'h2;
    localparam logic [2:0] CSEL_DIV64 = 3'h6;
    localparam logic [1:0] CSEL_RC_LOW = 2'h3;

    function automatic logic [4:0] acq_len(input logic [2:0] code);
        logic [4:0] len;
        len = 5'h00;
        case (code)
            3'h1: len = ACQ_LEN_1;
            3'h2: len = ACQ_LEN_2;
            3'h3: len = ACQ_LEN_3;
            3'h4: len = ACQ_LEN_4;
            3'h5: len = ACQ_LEN_5;
            3'h6: len = ACQ_LEN_6;
            3'h7: len = ACQ_LEN_7;
            default: len = 5'h00;
        endcase
        return len;
    endfunction

    // Returns the divide ratio minus one, so a counter compares against it directly.
    function automatic logic [5:0] div_last(input logic [2:0] code);
        logic [5:0] last;
        last = 6'h01;
        case (code)
            CSEL_DIV2: last = 6'h01;
            CSEL_DIV4: last = 6'h03;
            CSEL_DIV8: last = 6'h07;
            CSEL_DIV16: last = 6'h0F;
            CSEL_DIV32: last = 6'h1F;
            CSEL_DIV64: last = 6'h3F;
            default: last = 6'h01;
        endcase
        return last;
    endfunction

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_SAMPLE, ST_ACQ, ST_CONV} seq_state_e;

    typedef struct packed {
        logic [2:0] acq_sel;
        logic [2:0] clk_sel;
    } ctl_word_s;

    typedef struct packed {
        seq_state_e state;
        logic [4:0] cnt;
        logic start_done;
        logic flag;
        ctl_word_s ctl;
        logic conv_start;
        logic [2:0] rc_sync;
    } ctrl_s;

    typedef struct packed {
        logic [5:0] cnt;
    } div_s;

endpackage

/* File: src/tad_divider.sv */
// Conversion-clock period generator: one tick per bit period.
// Assumes rc_rise is already synchronised to core_clk and is one cycle wide.
`timescale 1ns/1ps
module tad_divider
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [2:0] clk_sel,
    input wire logic restart,
    input wire logic rc_rise,
    output logic tick
);

    adc_seq_pkg::div_s st_reg;
    adc_seq_pkg::div_s st_next;
    logic rc_mode;
    logic [5:0] last;

    // ------------------------------------------------------------
    // Ratio decode and tick
    // ------------------------------------------------------------
    // Codes with both low bits set pick the RC oscillator; the high bit is ignored there.
    assign rc_mode = (clk_sel[1:0] == adc_seq_pkg::CSEL_RC_LOW);
    assign last = adc_seq_pkg::div_last(clk_sel);
    // A restart holds the tick off; for divided clocks it also realigns the counter so the first period after it is a full one.
    assign tick = !restart && (rc_mode ? rc_rise : (st_reg.cnt == last));

    // Counter wraps at the selected ratio; a restart realigns the period boundary.
    always_comb
    begin
        st_next = st_reg;
        if (restart || rc_mode || st_reg.cnt >= last)
        begin
            st_next.cnt = 6'h00;
        end
        else
        begin
            st_next.cnt = st_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

endmodule

/* File: testbench/conv_core_model.sv */
// Behavioural model of the channel multiplexer and converter core.
// Assumes it watches the sequencer's core-side outputs on the same core clock.
`timescale 1ns/1ps
module conv_core_model
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sampling,
    input wire logic conv_start,
    input wire logic bit_strobe,
    output logic rc_osc,
    output logic [11:0] conv_len,
    output logic [4:0] bits_taken,
    output logic [7:0] starts_seen
);
    // ------------------------------------------------------------
    // RC oscillator and bit bookkeeping
    // ------------------------------------------------------------
    // The RC source runs free with no ratio to core_clk, so its ticks drift in phase.
    initial
    begin
        rc_osc = 1'b0;
        forever #155 rc_osc = ~rc_osc;
    end

    // A bit is resolved per strobe only while the sample switch is open.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_len <= 12'h000;
            bits_taken <= 5'h00;
            starts_seen <= 8'h00;
        end
        else if (conv_start)
        begin
            conv_len <= 12'h001;
            bits_taken <= {4'h0, bit_strobe};
            starts_seen <= starts_seen + 8'h01;
        end
        else if (!sampling)
        begin
            conv_len <= conv_len + 12'h001;
            bits_taken <= bits_taken + {4'h0, bit_strobe};
        end
    end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the acquisition and conversion-clock sequencer.
// Assumes the core model supplies the RC clock and counts resolved bits.
`timescale 1ns/1ps
module tb;
    logic core_clk;
    logic rstn;
    logic ctl_wr;
    adc_seq_pkg::ctl_word_s ctl_wdata;
    logic start_set;
    logic flag_clear;
    logic rc_osc;
    logic [2:0] acq_time_select;
    logic [2:0] conv_clock_select;
    logic start_done;
    logic conv_complete_flag;
    logic sampling;
    logic conv_start;
    logic bit_strobe;
    logic [11:0] conv_len;
    logic [4:0] bits_taken;
    logic [7:0] starts_seen;
    int fails;
    int check_count;
    logic [31:0] rnd;

    adc_acq_ctrl u_adc_acq_ctrl (.core_clk(core_clk), .rstn(rstn), .ctl_wr(ctl_wr),
        .ctl_wdata(ctl_wdata), .start_set(start_set), .flag_clear(flag_clear),
        .rc_osc(rc_osc), .acq_time_select(acq_time_select),
        .conv_clock_select(conv_clock_select), .start_done(start_done),
        .conv_complete_flag(conv_complete_flag), .sampling(sampling),
        .conv_start(conv_start), .bit_strobe(bit_strobe));

    conv_core_model u_conv_core_model (.core_clk(core_clk), .rstn(rstn), .sampling(sampling),
        .conv_start(conv_start), .bit_strobe(bit_strobe), .rc_osc(rc_osc),
        .conv_len(conv_len), .bits_taken(bits_taken), .starts_seen(starts_seen));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Core clock at 25 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Core cycles per bit period; zero marks the RC source.
    function automatic int div_of(input logic [2:0] c);
        case (c)
            3'h0: return 2;
            3'h4: return 4;
            3'h1: return 8;
            3'h5: return 16;
            3'h2: return 32;
            3'h6: return 64;
            default: return 0;
        endcase
    endfunction

    function automatic int acq_of(input logic [2:0] c);
        int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
        return t[c];
    endfunction

    // ------------------------------------------------------------
    // One full conversion
    // ------------------------------------------------------------
    // The start/done bit is counted high cycle by cycle, so a gap between
    // acquisition and conversion would show as a long count.
    task automatic run_conv(input logic [2:0] acq, input logic [2:0] csel, input bit poke);
        int hi;
        int p;
        int n;
        logic [7:0] s0;
        p = div_of(csel);
        n = acq_of(acq) + 11;
        hi = 0;
        @(posedge core_clk);
        ctl_wr <= 1'b1;
        ctl_wdata <= '{acq_sel: acq, clk_sel: csel};
        @(posedge core_clk);
        ctl_wr <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        check(acq_time_select, acq);
        check(conv_clock_select, csel);
        s0 = starts_seen;
        @(posedge core_clk);
        start_set <= 1'b1;
        @(posedge core_clk);
        start_set <= 1'b0;
        #1;
        check(start_done, 1'b1);
        // A poke lands a second start on an odd edge, clear of any divided tick, and a
        // clear on the completion edge itself for divided clocks, where the completion has to win.
        while (start_done === 1'b1 && hi < 5000)
        begin
            hi++;
            @(posedge core_clk);
            start_set <= poke && (hi == 4);
            flag_clear <= poke && (hi == n * p - 1);
            #1;
        end
        if (p != 0)
        begin
            check(hi, n * p);
            check(conv_len, 11 * p);
        end
        else
            check(hi >= (n - 1) * 7 && hi <= n * 8 + 6, 1'b1);
        check(bits_taken, 11);
        check(starts_seen - s0, 1);
        check({start_done, conv_complete_flag, sampling}, 3'b011);
        repeat (3) @(posedge core_clk);
        #1;
        check(conv_complete_flag, 1'b1);
        @(posedge core_clk);
        flag_clear <= 1'b1;
        @(posedge core_clk);
        flag_clear <= 1'b0;
        #1;
        check(conv_complete_flag, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        ctl_wr = 1'b0;
        ctl_wdata = '{acq_sel: 3'h0, clk_sel: 3'h0};
        start_set = 1'b0;
        flag_clear = 1'b0;
        fails = 0;
        check_count = 0;
        void'($urandom(32'h407A210C));
        repeat (8) @(posedge core_clk);
        #1;
        check({acq_time_select, conv_clock_select, start_done, conv_complete_flag, sampling},
              9'h001);
        @(posedge core_clk);
        rstn <= 1'b1;
        // Every select code, the slowest ones too, since software may pick any.
        for (int i = 0; i < 8; i++)
            run_conv(3'h0, i[2:0], i == 0);
        for (int a = 1; a < 8; a++)
            run_conv(a[2:0], 3'h0, a == 7);
        // Random fields and pokes; one draw feeds all three arguments.
        repeat (6)
        begin
            rnd = $urandom();
            run_conv(rnd[2:0], rnd[5:3], rnd[6]);
        end
        tally_and_finish();
    end

    // Longest expected run is well under this span.
    initial
    begin
        repeat (40000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end
endmodule
